// ==== logic/sbd_fabric.sv ====
// system bus fabric: dma-first arbiter, address decoder, sram macro control,
// quad spi master-core selector
// assumes masters hold a request until done, slaves answer by ready, one clock
`include "sbd_regs.svh"

// Function
// - on simultaneous requests the dma engine is granted before the processor.
// - addresses 0x0000_0000 to 0x0003_FFFF go to the rom.
// - addresses 0x1000_0000 to 0x10FF_FFFF go to the mapped flash window.
// - addresses 0x2000_0000 to 0x2001_7FFF go to system sram.
// - addresses 0x3000_0000 to 0x3000_FFFF go to the radio link region.
// - addresses 0x4000_0000 to 0x4000_FFFF go to the first peripheral window.
// - addresses 0x4001_0000 to 0x4001_1FFF go to gpio.
// - addresses 0x4001_F000 to 0x4001_FFFF go to system control.
// - addresses 0x5000_0000 to 0x5000_FFFF go to the second peripheral window.
// - addresses 0x6000_0000 to 0x6000_0FFF go to otp memory.
// - addresses 0x7000_0000 to 0x7000_0FFF go to dma registers.
// - addresses 0x8000_0000 to 0x8000_0FFF go to the microphone interface.
// - sram is eight 16 KB macros, two kept for the link controller.
// - each macro's power state is chosen per low-power state independently.
// - quad spi serial clock never exceeds 32 MHz.
// - at most one of three master cores owns the quad spi port; select value 3 grants none.
// - single-bit core drives flash reads and writes by indirect addressing.
// - software-protocol core only shifts bits; software supplies the protocol.
// - direct-mapped core bridges the flash window with full hardware protocol.
// - bus data is little-endian on a 32-bit path.
// - the quad spi side runs on mclk_in; a separate high-power clock domain lies outside the fabric.
module sbd_fabric #(
	parameter int NUM_LP   = 4,
	parameter int DIV_W    = 8
) (
	input  wire logic                                      mclk_in,
	input  wire logic                                      srst_in,
	input  wire sbd_pkg::sbd_req_t                         cpu_req_in,
	output      sbd_pkg::sbd_rsp_t                         cpu_rsp_out,
	input  wire sbd_pkg::sbd_req_t                         dma_req_in,
	output      sbd_pkg::sbd_rsp_t                         dma_rsp_out,
	output      sbd_pkg::sbd_slv_req_t                     slv_req_out,
	input  wire logic [`SBD_NUM_REGIONS-1:0]               slv_ready_in,
	input  wire logic [`SBD_NUM_REGIONS-1:0][31:0]         slv_rdata_in,
	output      logic [`SBD_NUM_MACROS-1:0]                sram_macro_sel_out,
	input  wire logic [$clog2(NUM_LP)-1:0]                 lp_state_in,
	input  wire logic [NUM_LP-1:0][`SBD_NUM_MACROS-1:0][1:0] sram_pwr_cfg_in,
	output      logic [`SBD_NUM_MACROS-1:0][1:0]           sram_macro_pwr_out,
	input  wire logic [1:0]                                qspi_core_sel_in,
	input  wire sbd_pkg::sbd_qspi_pins_t [`SBD_QSPI_CORES-1:0] qspi_core_pins_in,
	output      logic [`SBD_QSPI_CORES-1:0]                qspi_core_grant_out,
	output      logic [`SBD_QSPI_CORES-1:0][3:0]           qspi_core_din_out,
	output      sbd_pkg::sbd_qspi_pins_t                   qspi_pins_out,
	input  wire logic [3:0]                                qspi_din_in,
	output      logic                                      qspi_tick_out
);
	import sbd_pkg::*;

	localparam int QSPI_DIV = (`SBD_MCLK_HZ + `SBD_QSPI_MAX_HZ - 1) / `SBD_QSPI_MAX_HZ;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(QSPI_DIV - 1);

	typedef enum logic [1:0] {S_IDLE, S_ACCESS, S_DONE} sbd_state_t;

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction : in_range

	function automatic sbd_region_t decode(input logic [31:0] a);
		if (in_range(a, `SBD_ROM_BASE, `SBD_ROM_LAST))
			decode = SBD_RG_ROM;
		else if (in_range(a, `SBD_FLASH_BASE, `SBD_FLASH_LAST))
			decode = SBD_RG_FLASH;
		else if (in_range(a, `SBD_SRAM_BASE, `SBD_SRAM_LAST))
			decode = SBD_RG_SRAM;
		else if (in_range(a, `SBD_LINK_BASE, `SBD_LINK_LAST))
			decode = SBD_RG_LINK;
		else if (in_range(a, `SBD_PER0_BASE, `SBD_PER0_LAST))
			decode = SBD_RG_PER0;
		else if (in_range(a, `SBD_GPIO_BASE, `SBD_GPIO_LAST))
			decode = SBD_RG_GPIO;
		else if (in_range(a, `SBD_SYSC_BASE, `SBD_SYSC_LAST))
			decode = SBD_RG_SYSC;
		else if (in_range(a, `SBD_PER1_BASE, `SBD_PER1_LAST))
			decode = SBD_RG_PER1;
		else if (in_range(a, `SBD_OTP_BASE, `SBD_OTP_LAST))
			decode = SBD_RG_OTP;
		else if (in_range(a, `SBD_DMA_BASE, `SBD_DMA_LAST))
			decode = SBD_RG_DMA;
		else if (in_range(a, `SBD_MIC_BASE, `SBD_MIC_LAST))
			decode = SBD_RG_MIC;
		else
			decode = SBD_RG_NONE;
	endfunction : decode

	// little-endian lanes: byte n of the word sits on bits 8n+7..8n
	function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] lsb);
		logic [3:0] m;
		m = 4'h0;
		unique case (size)
			2'h0:    m = 4'h1 << lsb;
			2'h1:    m = 4'h3 << lsb;
			2'h2:    m = 4'hF;
			default: m = 4'h0;
		endcase
		lane_mask = m;
	endfunction : lane_mask

	function automatic logic aligned(input logic [1:0] size, input logic [1:0] lsb);
		unique case (size)
			2'h0:    aligned = 1'b1;
			2'h1:    aligned = (lsb[0] == 1'b0);
			2'h2:    aligned = (lsb == 2'h0);
			default: aligned = 1'b0;
		endcase
	endfunction : aligned

	sbd_state_t   state_reg;
	logic         owner_dma_reg;
	sbd_region_t  region_reg;
	logic         write_reg;
	logic [31:0]  addr_reg;
	logic [31:0]  wdata_reg;
	logic [3:0]   be_reg;
	logic         err_reg;
	logic [31:0]  rdata_reg;

	logic         take_dma;
	logic         take_any;
	sbd_req_t     pick;
	sbd_region_t  pick_region;
	logic         pick_ok;
	logic         slv_ready;
	logic [31:0]  slv_rdata;

	assign take_dma    = dma_req_in.valid;
	assign take_any    = dma_req_in.valid || cpu_req_in.valid;
	assign pick        = take_dma ? dma_req_in : cpu_req_in;
	assign pick_region = decode(pick.addr);
	assign pick_ok     = (pick_region != SBD_RG_NONE) && aligned(pick.size, pick.addr[1:0]);

	always_comb
	begin
		slv_ready = 1'b0;
		slv_rdata = 32'h0000_0000;
		if (region_reg != SBD_RG_NONE)
		begin
			slv_ready = slv_ready_in[region_reg];
			slv_rdata = slv_rdata_in[region_reg];
		end
	end

	// transfer sequencer: one transfer in flight, a gap cycle after each answer
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			state_reg <= S_IDLE;
		else
		begin
			unique case (state_reg)
				S_IDLE:
					if (take_any)
						state_reg <= pick_ok ? S_ACCESS : S_DONE;
				S_ACCESS:
					if (slv_ready)
						state_reg <= S_DONE;
				S_DONE:
					state_reg <= S_IDLE;
			endcase
		end
	end

	// captured request
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			owner_dma_reg <= 1'b0;
			region_reg    <= SBD_RG_NONE;
			write_reg     <= 1'b0;
			addr_reg      <= 32'h0000_0000;
			wdata_reg     <= 32'h0000_0000;
			be_reg        <= 4'h0;
		end
		else if (state_reg == S_IDLE && take_any)
		begin
			owner_dma_reg <= take_dma;
			region_reg    <= pick_ok ? pick_region : SBD_RG_NONE;
			write_reg     <= pick.write;
			addr_reg      <= pick.addr; // low bits kept for the read lane shift
			wdata_reg     <= pick.wdata << {pick.addr[1:0], 3'h0};
			be_reg        <= pick_ok ? lane_mask(pick.size, pick.addr[1:0]) : 4'h0;
		end
	end

	// answer data, shifted back to the low lanes
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			err_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end
		else if (state_reg == S_IDLE && take_any)
		begin
			err_reg   <= !pick_ok;
			rdata_reg <= 32'h0000_0000;
		end
		else if (state_reg == S_ACCESS && slv_ready && !write_reg)
			rdata_reg <= slv_rdata >> {addr_reg[1:0], 3'h0};
	end

	// the flash window goes to the direct-mapped core through slave port FLASH
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			slv_req_out <= '0;
		else if (state_reg == S_IDLE && take_any && pick_ok)
		begin
			slv_req_out.sel   <= `SBD_NUM_REGIONS'(1) << pick_region;
			slv_req_out.write <= pick.write;
			slv_req_out.addr  <= {pick.addr[31:2], 2'h0};
			slv_req_out.wdata <= pick.wdata << {pick.addr[1:0], 3'h0};
			slv_req_out.be    <= lane_mask(pick.size, pick.addr[1:0]);
		end
		else if (state_reg == S_ACCESS && slv_ready)
			slv_req_out <= '0;
	end

	// responses to the two masters
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			cpu_rsp_out <= '0;
			dma_rsp_out <= '0;
		end
		else
		begin
			cpu_rsp_out <= '0;
			dma_rsp_out <= '0;
			if ((state_reg == S_ACCESS && slv_ready) ||
				(state_reg == S_IDLE && take_any && !pick_ok))
			begin
				if (state_reg == S_IDLE ? take_dma : owner_dma_reg)
				begin
					dma_rsp_out.done  <= 1'b1;
					dma_rsp_out.err   <= (state_reg == S_IDLE);
					dma_rsp_out.rdata <= (state_reg == S_IDLE || write_reg) ? 32'h0000_0000 :
						slv_rdata >> {addr_reg[1:0], 3'h0};
				end
				else
				begin
					cpu_rsp_out.done  <= 1'b1;
					cpu_rsp_out.err   <= (state_reg == S_IDLE);
					cpu_rsp_out.rdata <= (state_reg == S_IDLE || write_reg) ? 32'h0000_0000 :
						slv_rdata >> {addr_reg[1:0], 3'h0};
				end
			end
		end
	end

	// sram macro select: 16 KB per macro, link region low 32 KB on macros 6 and 7
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			sram_macro_sel_out <= '0;
		else if (state_reg == S_IDLE && take_any && pick_ok)
		begin
			sram_macro_sel_out <= '0;
			if (pick_region == SBD_RG_SRAM)
				sram_macro_sel_out <= `SBD_NUM_MACROS'(1) <<
					pick.addr[`SBD_MACRO_LSB +: `SBD_MACRO_IDX_W];
			else if (pick_region == SBD_RG_LINK && pick.addr[`SBD_LINK_MACRO_TOP] == 1'b0)
				sram_macro_sel_out <= `SBD_NUM_MACROS'(1) <<
					(`SBD_LINK_MACRO0 + {2'h0, pick.addr[`SBD_MACRO_LSB]});
		end
		else if (state_reg == S_ACCESS && slv_ready)
			sram_macro_sel_out <= '0;
	end

	// per-macro power state follows the table row of the current low-power state
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			for (int m = 0; m < `SBD_NUM_MACROS; m++)
				sram_macro_pwr_out[m] <= `SBD_PWR_ON;
		end
		else
			sram_macro_pwr_out <= sram_pwr_cfg_in[lp_state_in];
	end

	// serial-rate tick for the master cores, divided down to at most the flash limit
	logic [DIV_W-1:0] div_cnt_reg;

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			div_cnt_reg   <= '0;
			qspi_tick_out <= 1'b0;
		end
		else if (div_cnt_reg >= DIV_LAST)
		begin
			div_cnt_reg   <= '0;
			qspi_tick_out <= 1'b1;
		end
		else
		begin
			div_cnt_reg   <= div_cnt_reg + DIV_W'(1);
			qspi_tick_out <= 1'b0;
		end
	end

	// core ownership: changes only while the current owner holds chip select high;
	// core 0 single-bit, core 1 software-shift, core 2 direct-mapped bridge
	logic [`SBD_QSPI_CORES-1:0] grant_next;

	always_comb
	begin
		grant_next = '0;
		if (qspi_core_sel_in < 2'(`SBD_QSPI_CORES))
			grant_next = `SBD_QSPI_CORES'(1) << qspi_core_sel_in;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			qspi_core_grant_out <= '0;
		else if (qspi_pins_out.cs_n)
			qspi_core_grant_out <= grant_next;
	end

	// pin mux from the granted core, idle pins when none owns the port
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			qspi_pins_out      <= '{sclk: 1'b0, cs_n: 1'b1, dout: 4'h0, oe_n: 4'hF};
			qspi_core_din_out  <= '0;
		end
		else
		begin
			qspi_pins_out     <= '{sclk: 1'b0, cs_n: 1'b1, dout: 4'h0, oe_n: 4'hF};
			qspi_core_din_out <= '0;
			for (int c = 0; c < `SBD_QSPI_CORES; c++)
			begin
				if (qspi_core_grant_out[c])
				begin
					qspi_pins_out        <= qspi_core_pins_in[c];
					qspi_core_din_out[c] <= qspi_din_in;
				end
			end
		end
	end

	// the flash side shares mclk_in here; a separate high-power clock is outside
	// this fabric and must retime qspi_pins_out if one is used

endmodule : sbd_fabric

// ==== logic/sbd_pkg.sv ====
// types shared by the system bus decoder fabric and its surroundings
// assumes sbd_regs.svh on the include path
`include "sbd_regs.svh"

package sbd_pkg;

	typedef enum logic [3:0] {
		SBD_RG_ROM, SBD_RG_FLASH, SBD_RG_SRAM, SBD_RG_LINK, SBD_RG_PER0, SBD_RG_GPIO,
		SBD_RG_SYSC, SBD_RG_PER1, SBD_RG_OTP, SBD_RG_DMA, SBD_RG_MIC, SBD_RG_NONE
	} sbd_region_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sbd_req_t;

	typedef struct packed {
		logic        done;
		logic        err;
		logic [31:0] rdata;
	} sbd_rsp_t;

	typedef struct packed {
		logic [`SBD_NUM_REGIONS-1:0] sel;
		logic                        write;
		logic [31:0]                 addr;
		logic [31:0]                 wdata;
		logic [3:0]                  be;
	} sbd_slv_req_t;

	typedef struct packed {
		logic       sclk;
		logic       cs_n;
		logic [3:0] dout;
		logic [3:0] oe_n;
	} sbd_qspi_pins_t;

endpackage : sbd_pkg

// ==== logic/sbd_regs.svh ====
// address map, lane and timing constants for the system bus decoder
// assumes inclusion by bare name from the package and the fabric module
`ifndef SBD_REGS_SVH
`define SBD_REGS_SVH

`define SBD_ROM_BASE     32'h0000_0000
`define SBD_ROM_LAST     32'h0003_FFFF
`define SBD_FLASH_BASE   32'h1000_0000
`define SBD_FLASH_LAST   32'h10FF_FFFF
`define SBD_SRAM_BASE    32'h2000_0000
`define SBD_SRAM_LAST    32'h2001_7FFF
`define SBD_LINK_BASE    32'h3000_0000
`define SBD_LINK_LAST    32'h3000_FFFF
`define SBD_PER0_BASE    32'h4000_0000
`define SBD_PER0_LAST    32'h4000_FFFF
`define SBD_GPIO_BASE    32'h4001_0000
`define SBD_GPIO_LAST    32'h4001_1FFF
`define SBD_SYSC_BASE    32'h4001_F000
`define SBD_SYSC_LAST    32'h4001_FFFF
`define SBD_PER1_BASE    32'h5000_0000
`define SBD_PER1_LAST    32'h5000_FFFF
`define SBD_OTP_BASE     32'h6000_0000
`define SBD_OTP_LAST     32'h6000_0FFF
`define SBD_DMA_BASE     32'h7000_0000
`define SBD_DMA_LAST     32'h7000_0FFF
`define SBD_MIC_BASE     32'h8000_0000
`define SBD_MIC_LAST     32'h8000_0FFF

`define SBD_NUM_REGIONS  11
`define SBD_NUM_MACROS   8
`define SBD_MACRO_LSB    14
`define SBD_MACRO_IDX_W  3
`define SBD_LINK_MACRO0  3'h6
`define SBD_LINK_MACRO_TOP 15

`define SBD_PWR_ON       2'h0
`define SBD_PWR_RETAIN   2'h1
`define SBD_PWR_OFF      2'h2

`define SBD_MCLK_HZ      40000000
`define SBD_QSPI_MAX_HZ  32000000
`define SBD_QSPI_CORES   3

`endif

// ==== testbench/sbd_fabric_sva.sv ====
// checker on the fabric ports: arbitration, decode, sram power, quad spi mux
// assumes a bind onto sbd_fabric with its NUM_LP handed on
`include "sbd_regs.svh"
module sbd_fabric_sva import sbd_pkg::*; #(
	parameter int NUM_LP = 4
) (
	input wire logic                          mclk_in,
	input wire logic                          srst_in,
	input wire sbd_pkg::sbd_rsp_t             cpu_rsp_out,
	input wire sbd_pkg::sbd_rsp_t             dma_rsp_out,
	input wire sbd_pkg::sbd_slv_req_t         slv_req_out,
	input wire logic [`SBD_NUM_REGIONS-1:0]   slv_ready_in,
	input wire logic [`SBD_NUM_MACROS-1:0]    sram_macro_sel_out,
	input wire logic [$clog2(NUM_LP)-1:0]     lp_state_in,
	input wire logic [NUM_LP-1:0][7:0][1:0]   sram_pwr_cfg_in,
	input wire logic [7:0][1:0]               sram_macro_pwr_out,
	input wire logic [1:0]                    qspi_core_sel_in,
	input wire sbd_pkg::sbd_qspi_pins_t [2:0] qspi_core_pins_in,
	input wire logic [2:0]                    qspi_core_grant_out,
	input wire sbd_pkg::sbd_qspi_pins_t       qspi_pins_out,
	input wire logic                          qspi_tick_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	logic [7:0][1:0] cfg_now;
	assign cfg_now = sram_pwr_cfg_in[lp_state_in];
	chk_one_winner: assert property (!(cpu_rsp_out.done && dma_rsp_out.done))
		else $error("both masters completed in one cycle");
	chk_ready_done: assert property ((|(slv_req_out.sel & slv_ready_in)) |=>
		(cpu_rsp_out.done || dma_rsp_out.done) && slv_req_out.sel == '0)
		else $error("slave ready not followed by completion");
	chk_sel_onehot: assert property ($onehot0(slv_req_out.sel))
		else $error("more than one region selected");
	chk_err_nosel: assert property (cpu_rsp_out.err |-> cpu_rsp_out.done &&
		cpu_rsp_out.rdata == '0 && $past(slv_req_out.sel) == '0)
		else $error("error completion touched a slave");
	chk_word_lane: assert property (slv_req_out.sel != '0 |->
		slv_req_out.addr[1:0] == 2'h0 && slv_req_out.be != 4'h0)
		else $error("slave request not word aligned");
	chk_link_macro: assert property ((|sram_macro_sel_out[7:6]) |->
		slv_req_out.sel[3] && $onehot(sram_macro_sel_out))
		else $error("link macro used outside link region");
	chk_sram_macro: assert property ((|sram_macro_sel_out[5:0]) |-> slv_req_out.sel[2])
		else $error("general macro used outside sram region");
	chk_pwr_follow: assert property (!srst_in |=> sram_macro_pwr_out == $past(cfg_now))
		else $error("macro power does not follow state");
	chk_tick_rate: assert property (qspi_tick_out |=> !qspi_tick_out ##1 qspi_tick_out)
		else $error("serial tick rate wrong");
	chk_grant_decode: assert property (!srst_in && qspi_pins_out.cs_n |=>
		qspi_core_grant_out == 3'(4'h1 << $past(qspi_core_sel_in)))
		else $error("owner grant does not match select");
	chk_grant_hold: assert property (!qspi_pins_out.cs_n |=> $stable(qspi_core_grant_out))
		else $error("owner changed inside a frame");
	chk_pins_owner: assert property (qspi_core_grant_out == 3'h4 |=>
		qspi_pins_out == $past(qspi_core_pins_in[2]))
		else $error("pins do not follow mapped core");
	cover property (dma_rsp_out.done);
	cover property (cpu_rsp_out.done && cpu_rsp_out.err);
	cover property ($rose(qspi_core_grant_out[2]));
endmodule : sbd_fabric_sva

bind sbd_fabric sbd_fabric_sva #(.NUM_LP(NUM_LP)) i_sbd_fabric_sva (
	.mclk_in(mclk_in), .srst_in(srst_in), .cpu_rsp_out(cpu_rsp_out),
	.dma_rsp_out(dma_rsp_out), .slv_req_out(slv_req_out), .slv_ready_in(slv_ready_in),
	.sram_macro_sel_out(sram_macro_sel_out), .lp_state_in(lp_state_in),
	.sram_pwr_cfg_in(sram_pwr_cfg_in), .sram_macro_pwr_out(sram_macro_pwr_out),
	.qspi_core_sel_in(qspi_core_sel_in), .qspi_core_pins_in(qspi_core_pins_in),
	.qspi_core_grant_out(qspi_core_grant_out), .qspi_pins_out(qspi_pins_out),
	.qspi_tick_out(qspi_tick_out));

// ==== testbench/sbd_fabric_test.sv ====
// self-checking bench for the system bus fabric
// assumes the slave model and the bound checker are compiled alongside
module sbd_fabric_test import sbd_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [31:0] lo; logic [31:0] hi;} sbd_row_t;
	sbd_row_t rows [11] = '{'{32'h0000_0000, 32'h0003_FFFF}, '{32'h1000_0000, 32'h10FF_FFFF},
		'{32'h2000_0000, 32'h2001_7FFF}, '{32'h3000_0000, 32'h3000_FFFF},
		'{32'h4000_0000, 32'h4000_FFFF}, '{32'h4001_0000, 32'h4001_1FFF},
		'{32'h4001_F000, 32'h4001_FFFF}, '{32'h5000_0000, 32'h5000_FFFF},
		'{32'h6000_0000, 32'h6000_0FFF}, '{32'h7000_0000, 32'h7000_0FFF},
		'{32'h8000_0000, 32'h8000_0FFF}};
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	sbd_req_t cpu_req = '0;
	sbd_req_t dma_req = '0;
	sbd_rsp_t cpu_rsp, dma_rsp;
	sbd_slv_req_t slv_req;
	logic [10:0] slv_ready, es, seen_sel;
	logic [10:0][31:0] slv_rdata;
	logic [7:0] mac_sel, seen_mac;
	logic [1:0] lp_state = 2'h0;
	logic [1:0] core_sel = 2'h3;
	logic [3:0][7:0][1:0] pwr_cfg;
	logic [7:0][1:0] pwr;
	sbd_qspi_pins_t [2:0] core_pins;
	sbd_qspi_pins_t qpins;
	logic [2:0] grant;
	logic [2:0][3:0] core_din;
	logic [3:0] flash_din = 4'h9;
	logic [2:0] dly = 3'h0;
	logic tick;
	int fail_count = 0;
	int checks = 0;
	int n;

	always #12.5 mclk_in = ~mclk_in;

	sbd_fabric #(.NUM_LP(4), .DIV_W(8)) i_sbd_fabric (.mclk_in(mclk_in), .srst_in(srst_in),
		.cpu_req_in(cpu_req), .cpu_rsp_out(cpu_rsp), .dma_req_in(dma_req), .dma_rsp_out(dma_rsp),
		.slv_req_out(slv_req), .slv_ready_in(slv_ready), .slv_rdata_in(slv_rdata),
		.sram_macro_sel_out(mac_sel), .lp_state_in(lp_state), .sram_pwr_cfg_in(pwr_cfg),
		.sram_macro_pwr_out(pwr), .qspi_core_sel_in(core_sel), .qspi_core_pins_in(core_pins),
		.qspi_core_grant_out(grant), .qspi_core_din_out(core_din), .qspi_pins_out(qpins),
		.qspi_din_in(flash_din), .qspi_tick_out(tick));
	sbd_slave_model i_sbd_slave_model (.mclk_in(mclk_in), .srst_in(srst_in), .dly_in(dly),
		.slv_req_in(slv_req), .ready_out(slv_ready), .rdata_out(slv_rdata));

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one transfer by either master, bounded wait for its completion
	task automatic xs(input logic d, w, input logic [1:0] sz, input logic [31:0] a, wd,
		input logic ee, input logic [10:0] sel, input logic [31:0] er);
		sbd_rsp_t rs;
		@(posedge mclk_in);
		seen_sel = '0;
		seen_mac = '0;
		if (d)
			dma_req <= '{1'b1, w, sz, a, wd};
		else
			cpu_req <= '{1'b1, w, sz, a, wd};
		for (n = 0; n < 40; n++)
		begin
			@(posedge mclk_in);
			rs = d ? dma_rsp : cpu_rsp;
			seen_sel |= slv_req.sel;
			seen_mac |= mac_sel;
			if (rs.done === 1'b1)
				break;
		end
		chk("done", 1, rs.done);
		if (n == 40)
			report_and_stop;
		dma_req <= '0;
		cpu_req <= '0;
		chk("err", ee, rs.err);
		chk("sel", sel, seen_sel);
		if (!w)
			chk("rdata", er, rs.rdata);
	endtask : xs

	task automatic do_reset;
		srst_in <= 1'b1;
		repeat (5) @(posedge mclk_in);
		srst_in <= 1'b0;
		cpu_req <= '0;
		chk("reset outs", 0, {cpu_rsp.done, dma_rsp.done, slv_req.sel, grant, mac_sel, tick});
		chk("reset pwr", 0, pwr);
		chk("reset pins", 32'h10F, qpins);
		$display("test reset done");
	endtask : do_reset

	initial
	begin
		for (int s = 0; s < 4; s++)
			for (int m = 0; m < 8; m++)
				pwr_cfg[s][m] = 2'((s + m) % 3);
		for (int c = 0; c < 3; c++)
			core_pins[c] = '{1'b0, 1'b1, 4'(c + 1), 4'(c + 8)};
		do_reset;
		for (int i = 0; i < 11; i++)
		begin
			es = 11'h1 << i;
			xs(i[0], 1, 2, rows[i].lo, ~rows[i].lo, 0, es, 0);
			xs(!i[0], 0, 2, rows[i].lo, 0, 0, es, ~rows[i].lo);
			xs(i[0], 1, 2, rows[i].hi - 3, i, 0, es, 0);
			xs(!i[0], 0, 2, rows[i].hi - 3, 0, 0, es, i);
			xs(i[0], 1, 2, rows[i].hi + 1, 7, i != 4, i == 4 ? 11'h20 : 11'h0, 0);
		end
		$display("test regions done");
		xs(0, 1, 2, 32'h2000_0010, 0, 0, 11'h4, 0);
		xs(1, 1, 0, 32'h2000_0012, 32'hA5, 0, 11'h4, 0);
		xs(0, 0, 2, 32'h2000_0010, 0, 0, 11'h4, 32'h00A5_0000);
		xs(1, 0, 1, 32'h2000_0012, 0, 0, 11'h4, 32'hA5);
		xs(0, 0, 1, 32'h2000_0011, 0, 1, 11'h0, 0);
		xs(1, 0, 3, 32'h2000_0010, 0, 1, 11'h0, 0);
		xs(0, 1, 2, 32'h2001_4004, 0, 0, 11'h4, 0);
		chk("macro", 8'h20, seen_mac);
		xs(1, 1, 2, 32'h3000_4000, 0, 0, 11'h8, 0);
		chk("macro", 8'h80, seen_mac);
		xs(1, 1, 2, 32'h3000_8000, 0, 0, 11'h8, 0);
		chk("macro", 0, seen_mac);
		$display("test lanes done");
		@(posedge mclk_in);
		dly <= 3'h5;
		cpu_req <= '{1'b1, 1'b1, 2'h2, 32'h2000_0020, 32'h1};
		dma_req <= '{1'b1, 1'b1, 2'h2, 32'h3000_0024, 32'h2};
		for (n = 0; n < 40 && dma_rsp.done !== 1'b1 && cpu_rsp.done !== 1'b1; n++)
			@(posedge mclk_in);
		chk("dma first", 1, dma_rsp.done);
		if (n == 40)
			report_and_stop;
		dma_req <= '0;
		for (n = 0; n < 40 && cpu_rsp.done !== 1'b1; n++)
			@(posedge mclk_in);
		chk("cpu later", 1, cpu_rsp.done);
		cpu_req <= '0;
		if (n == 40)
			report_and_stop;
		$display("test arbitration done");
		@(posedge mclk_in);
		cpu_req <= '{1'b1, 1'b0, 2'h2, 32'h2000_0010, 32'h0};
		repeat (3) @(posedge mclk_in);
		do_reset;
		dly <= 3'h0;
		for (int s = 0; s < 4; s++)
		begin
			lp_state <= s[1:0];
			repeat (2) @(posedge mclk_in);
			for (int m = 0; m < 8; m++)
				chk("power", (s + m) % 3, pwr[m]);
		end
		n = tick;
		@(posedge mclk_in);
		chk("tick", !n, tick);
		$display("test power done");
		for (int c = 0; c < 4; c++)
		begin
			core_sel <= c[1:0];
			repeat (3) @(posedge mclk_in);
			chk("grant", c < 3 ? 1 << c : 0, grant);
			chk("pins", c < 3 ? core_pins[c] : 10'h10F, qpins);
			chk("din", c < 3 ? 12'h9 << 4 * c : 0, core_din);
		end
		core_sel <= 2'h1;
		repeat (3) @(posedge mclk_in);
		core_pins[1].cs_n <= 1'b0;
		repeat (3) @(posedge mclk_in);
		core_sel <= 2'h2;
		repeat (3) @(posedge mclk_in);
		chk("grant held", 3'h2, grant);
		core_pins[1].cs_n <= 1'b1;
		repeat (3) @(posedge mclk_in);
		chk("grant moved", 3'h4, grant);
		$display("test quad spi done");
		report_and_stop;
	end
endmodule : sbd_fabric_test

// ==== testbench/sbd_slave_model.sv ====
// slave side of the fabric: every region answers ready after a set delay
// assumes the fabric holds its slave request until ready is sampled
module sbd_slave_model import sbd_pkg::*; (
	input  wire logic                  mclk_in,
	input  wire logic                  srst_in,
	input  wire logic [2:0]            dly_in,
	input  wire sbd_pkg::sbd_slv_req_t slv_req_in,
	output      logic [10:0]           ready_out,
	output      logic [10:0][31:0]     rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem_reg [11][16];
	logic [2:0]  wait_reg;
	logic        rdy_reg;
	logic [15:0] junk_reg;
	logic [3:0]  widx;
	assign widx = slv_req_in.addr[5:2];
	assign ready_out = rdy_reg ? slv_req_in.sel : '0;
	// read word only while ready, a moving pattern otherwise
	always_comb
		for (int r = 0; r < 11; r++)
			rdata_out[r] = (rdy_reg && slv_req_in.sel[r]) ? mem_reg[r][widx] : {junk_reg, ~junk_reg};
	always_ff @(posedge mclk_in)
	begin
		junk_reg <= srst_in ? 16'h0 : junk_reg + 16'h1;
		if (srst_in || slv_req_in.sel == '0 || rdy_reg)
		begin
			wait_reg <= 3'h0;
			rdy_reg  <= 1'b0;
		end
		else
		begin
			wait_reg <= wait_reg + 3'h1;
			rdy_reg  <= (wait_reg == dly_in);
		end
	end
	always_ff @(posedge mclk_in)
		for (int i = 0; i < 11; i++)
			for (int b = 0; b < 4; b++)
				if (rdy_reg && slv_req_in.write && slv_req_in.sel[i] && slv_req_in.be[b])
					mem_reg[i][widx][8*b +: 8] <= slv_req_in.wdata[8*b +: 8];
endmodule : sbd_slave_model
